// File: core/ptc_top.sv
// periodic timer control: 10-bit counter, clock select, modes, pin logic,
// with an AXI4-Lite register slave.
// assumes pins arrive asynchronous to aclk; aresetn is synchronous.
// Operation
// (RULE1) clock select picks counter clock source
// (RULE2) counter on rising edge zeroes counter
// (RULE3) counter off stops and keeps value
// (RULE4) on rising edge loads initial pin level
// (RULE5) control 0 low three bits read zero
// (RULE6) mode field selects operating mode
// (RULE7) software stops timer before mode change
// (RULE8) timer/counter mode pin level undefined
// (RULE9) compare A match: none, low, high, toggle
// (RULE10) pwm mode: inactive, active, pwm, pulse
// (RULE11) capture edge: rise, fall, both, off
// (RULE12) match equal to current level: no change
// (RULE13) pin function changed only while off
// (RULE14) initial level or active polarity bit
// (RULE15) invert bit flips pin, not timer mode
// (RULE16) capture source: capture pin or clock pin
// (RULE17) clear select: A match or P/overflow
// (RULE18) overflow clear only when P zero
// (RULE19) clear select ignored in pwm modes
// (RULE20) low byte reads counter bits 7..0
// (RULE21) high byte reads counter bits 9..8
// (RULE22) pause holds, resume from held value
// (RULE23) external clock synchronised, edge detected
// (RULE24) running counter increments per active edge
//
// Chosen here: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ns
`include "ptc_params.svh"

module ptc_top
	import ptc_pkg::*;
#(
	parameter int CNT_W   = 10,
	parameter int SUB_DIV = `PTC_CLK_HZ / `PTC_SUB_HZ
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [7:0]   awaddr,
	input  wire logic         awvalid,
	output logic              awready,
	input  wire logic [31:0]  wdata,
	input  wire logic [3:0]   wstrb,
	input  wire logic         wvalid,
	output logic              wready,
	output logic [1:0]        bresp,
	output logic              bvalid,
	input  wire logic         bready,
	input  wire logic [7:0]   araddr,
	input  wire logic         arvalid,
	output logic              arready,
	output logic [31:0]       rdata,
	output logic [1:0]        rresp,
	output logic              rvalid,
	input  wire logic         rready,
	input  wire logic         external_clock_pin,
	input  wire logic         capture_input_pin,
	output logic              timer_output_pin,
	output logic              timer_output_enable
);

	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	// merge the two low byte lanes of a write into a 10-bit value
	function automatic logic [9:0] ptc_merge10(input logic [9:0]  old,
	                                           input logic [31:0] d,
	                                           input logic [3:0]  s);
		logic [9:0] r;
		r = old;
		if (s[0]) begin
			r[7:0] = d[7:0];
		end
		if (s[1]) begin
			r[9:8] = d[9:8];
		end
		return r;
	endfunction : ptc_merge10

	localparam logic [11:0] SUB_LAST = 12'(SUB_DIV - 1);
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	ptc_ctrl0_t       c0, next_c0;
	ptc_ctrl1_t       c1, next_c1;
	logic [CNT_W-1:0] cmp_a, next_cmp_a;
	logic [CNT_W-1:0] cmp_p, next_cmp_p;
	logic [2:0]       status, next_status;
	logic             aw_held, next_aw_held, w_held, next_w_held;
	logic [7:0]       aw_addr, next_aw_addr;
	logic [31:0]      w_data, next_w_data;
	logic [3:0]       w_strb, next_w_strb;
	logic             next_awready, next_wready, next_bvalid;
	logic             next_arready, next_rvalid;
	logic [1:0]       next_bresp, next_rresp;
	logic [31:0]      next_rdata;
	logic             ext_s1, ext_s2, ext_s3, cap_s1, cap_s2, cap_s3;
	logic             on_prev;
	logic [CNT_W-1:0] count, next_count;
	logic             out_level, next_out_level;
	logic             pulse_done, next_pulse_done;
	logic [5:0]       presc, next_presc;
	logic [11:0]      sub_cnt, next_sub_cnt;
	logic             next_pin, next_en;
	logic             do_write, tick, on_rise, running, hit_a, hit_p;
	logic             clear_now, cap_hit, src_now, src_old, pwm_act;
	logic [CNT_W-1:0] inc;

	// ------------------------------------------------------------------
	// axi4-lite handshakes
	// ------------------------------------------------------------------
	// address and data are held separately, so either may come first
	assign do_write = aw_held & w_held & ~bvalid;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_addr = aw_addr;
		next_w_data  = w_data;
		next_w_strb  = w_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		if (awvalid & awready) begin
			next_aw_held = 1'b1;
			next_aw_addr = awaddr;
		end
		if (wvalid & wready) begin
			next_w_held = 1'b1;
			next_w_data = wdata;
			next_w_strb = wstrb;
		end
		if (do_write) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			case (aw_addr)
				`PTC_OFF_CTRL0, `PTC_OFF_CTRL1, `PTC_OFF_CNT_LO,
				`PTC_OFF_CNT_HI, `PTC_OFF_CMP_A, `PTC_OFF_CMP_P,
				`PTC_OFF_STATUS: next_bresp = RESP_OK;
				default:         next_bresp = RESP_ERR;
			endcase
		end else if (bvalid & bready) begin
			next_bvalid = 1'b0;
		end
		// no new address or data until the response has gone
		next_awready = ~next_aw_held & ~next_bvalid;
		next_wready  = ~next_w_held & ~next_bvalid;
	end

	// read: one outstanding, data registered with the answer
	always_comb begin
		next_rvalid = rvalid;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (arvalid & arready) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OK;
			next_rdata  = 32'h0000_0000;
			case (araddr)
				`PTC_OFF_CTRL0:  next_rdata[`PTC_C0_MSB:`PTC_C0_LSB] = c0; // RULE5
				`PTC_OFF_CTRL1:  next_rdata[7:0] = c1;
				`PTC_OFF_CNT_LO: next_rdata[7:0] = count[7:0]; // RULE20
				`PTC_OFF_CNT_HI: next_rdata[1:0] = count[9:8]; // RULE21
				`PTC_OFF_CMP_A:  next_rdata[9:0] = cmp_a;
				`PTC_OFF_CMP_P:  next_rdata[9:0] = cmp_p;
				`PTC_OFF_STATUS: next_rdata[2:0] = status;
				default:         next_rresp = RESP_ERR;
			endcase
		end else if (rvalid & rready) begin
			next_rvalid = 1'b0;
		end
		next_arready = ~next_rvalid;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 8'h00;
			w_data  <= 32'h0000_0000;
			w_strb  <= 4'h0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= 2'h0;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= 2'h0;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			aw_addr <= next_aw_addr;
			w_data  <= next_w_data;
			w_strb  <= next_w_strb;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	// ------------------------------------------------------------------
	// software registers
	// ------------------------------------------------------------------
	// status: bit0 compare A match, bit1 compare P match, bit2 capture;
	// write one to clear, a same-cycle event wins
	always_comb begin
		next_c0     = c0;
		next_c1     = c1;
		next_cmp_a  = cmp_a;
		next_cmp_p  = cmp_p;
		next_status = status;
		if (do_write & w_strb[0]) begin
			case (aw_addr)
				`PTC_OFF_CTRL0:  next_c0 = w_data[`PTC_C0_MSB:`PTC_C0_LSB];
				`PTC_OFF_CTRL1:  next_c1 = w_data[7:0];
				`PTC_OFF_STATUS: next_status = status & ~w_data[2:0];
				default:         next_c0 = c0;
			endcase
		end
		if (do_write & aw_addr == `PTC_OFF_CMP_A) begin
			next_cmp_a = ptc_merge10(cmp_a, w_data, w_strb);
		end
		if (do_write & aw_addr == `PTC_OFF_CMP_P) begin
			next_cmp_p = ptc_merge10(cmp_p, w_data, w_strb);
		end
		// a capture overrides a software write to compare A
		if (cap_hit) begin
			next_cmp_a = count;
		end
		next_status = next_status | {cap_hit, hit_p, hit_a};
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			c0     <= `PTC_CTRL0_RST;
			c1     <= `PTC_CTRL1_RST;
			cmp_a  <= '0;
			cmp_p  <= '0;
			status <= `PTC_STATUS_RST;
		end else begin
			c0     <= next_c0;
			c1     <= next_c1;
			cmp_a  <= next_cmp_a;
			cmp_p  <= next_cmp_p;
			status <= next_status;
		end
	end

	// ------------------------------------------------------------------
	// pin synchronisers and clock enables
	// ------------------------------------------------------------------
	// stage 1 feeds only stage 2; edges come from stages 2 and 3
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
			cap_s1 <= 1'b0;
			cap_s2 <= 1'b0;
			cap_s3 <= 1'b0;
		end else begin
			ext_s1 <= external_clock_pin; // RULE23
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
			cap_s1 <= capture_input_pin;
			cap_s2 <= cap_s1;
			cap_s3 <= cap_s2;
		end
	end

	// high clock taken as aclk; the subclock is a divided enable
	always_comb begin
		next_presc   = presc + 6'h01;
		next_sub_cnt = (sub_cnt == SUB_LAST) ? 12'h000 : sub_cnt + 12'h001;
		case (c0.counter_clock_select) // RULE1
			PTC_CK_SYS4: tick = presc[1:0] == `PTC_DIV_SYS4;
			PTC_CK_SYS:  tick = 1'b1;
			PTC_CK_H16:  tick = presc[3:0] == `PTC_DIV_H16;
			PTC_CK_H64:  tick = presc == `PTC_DIV_H64;
			PTC_CK_SUB0, PTC_CK_SUB1: tick = sub_cnt == SUB_LAST;
			PTC_CK_RISE: tick = ext_s2 & ~ext_s3; // RULE23
			PTC_CK_FALL: tick = ~ext_s2 & ext_s3;
			default:     tick = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// counter, comparators, capture and output pin
	// ------------------------------------------------------------------
	assign on_rise = c0.counter_on & ~on_prev;
	// off powers down, pause holds; both keep the residual count
	assign running = c0.counter_on & on_prev & ~c0.counter_pause; // RULE3 RULE22
	assign inc     = count + 10'h001;
	// a zero compare value never matches, so the counter wraps at 3FF
	assign hit_a   = tick & running & (inc == cmp_a) & (cmp_a != '0);
	assign hit_p   = tick & running & (inc == cmp_p) & (cmp_p != '0); // RULE18
	assign src_now = c1.capture_source_select ? ext_s2 : cap_s2; // RULE16
	assign src_old = c1.capture_source_select ? ext_s3 : cap_s3;

	always_comb begin
		// pwm period always comes from P; clear select only outside pwm
		if (c1.mode_select == PTC_MODE_PWM) begin
			clear_now = hit_p; // RULE19
		end else begin
			clear_now = c1.clear_source_select ? hit_a : hit_p; // RULE17
		end
		case (c1.pin_function_select) // RULE11
			2'h0:    cap_hit = src_now & ~src_old;
			2'h1:    cap_hit = ~src_now & src_old;
			2'h2:    cap_hit = src_now ^ src_old;
			default: cap_hit = 1'b0;
		endcase
		cap_hit = cap_hit & running & (c1.mode_select == PTC_MODE_CAPTURE);
		case (c1.pin_function_select) // RULE10
			2'h0:    pwm_act = 1'b0;
			2'h1:    pwm_act = 1'b1;
			2'h2:    pwm_act = count < cmp_a;
			default: pwm_act = ~pulse_done & c0.counter_on;
		endcase
		next_count      = count;
		next_out_level  = out_level;
		next_pulse_done = pulse_done;
		if (on_rise) begin
			next_count      = '0; // RULE2
			next_out_level  = c1.output_initial_level; // RULE4 RULE14
			next_pulse_done = 1'b0;
		end else begin
			if (tick & running) begin
				next_count = clear_now ? '0 : inc; // RULE24
			end
			case (c1.mode_select) // RULE6
				PTC_MODE_COMPARE: begin
					// a level equal to the present one changes nothing
					if (hit_a) begin // RULE9 RULE12
						case (c1.pin_function_select)
							2'h1:    next_out_level = 1'b0;
							2'h2:    next_out_level = 1'b1;
							2'h3:    next_out_level = ~out_level;
							default: next_out_level = out_level;
						endcase
					end
				end
				PTC_MODE_PWM: begin
					if (hit_a & c1.pin_function_select == 2'h3) begin
						next_pulse_done = 1'b1;
					end
					// active level follows the polarity bit
					next_out_level = pwm_act ? c1.output_initial_level
					                         : ~c1.output_initial_level; // RULE14
				end
				default: next_out_level = out_level;
			endcase
		end
		// timer mode leaves the pin undriven, read back as low
		next_en  = c1.mode_select == PTC_MODE_COMPARE |
		           c1.mode_select == PTC_MODE_PWM; // RULE8
		next_pin = (c1.mode_select == PTC_MODE_TIMER) ? 1'b0
		           : out_level ^ c1.output_invert; // RULE15
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			on_prev             <= 1'b0;
			count               <= '0;
			out_level           <= 1'b0;
			pulse_done          <= 1'b0;
			presc               <= 6'h00;
			sub_cnt             <= 12'h000;
			timer_output_pin    <= 1'b0;
			timer_output_enable <= 1'b0;
		end else begin
			on_prev             <= c0.counter_on;
			count               <= next_count;
			out_level           <= next_out_level;
			pulse_done          <= next_pulse_done;
			presc               <= next_presc;
			sub_cnt             <= next_sub_cnt;
			timer_output_pin    <= next_pin;
			timer_output_enable <= next_en;
		end
	end

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_ON_CLEARS: assert property ( // RULE2
		on_rise |=> count == '0 ##1 (count == '0 || $past(tick)))
		else $error("counter not zeroed after switch on");
	AST_OFF_HOLDS: assert property ( // RULE3
		!c0.counter_on |=> count == $past(count))
		else $error("counter moved while off");
	AST_INIT_LEVEL: assert property ( // RULE4
		on_rise && c1.mode_select == PTC_MODE_COMPARE
		|=> out_level == $past(c1.output_initial_level))
		else $error("pin not at initial level after switch on");
	AST_CTRL0_LOW: assert property ( // RULE5
		arvalid && arready && araddr == `PTC_OFF_CTRL0
		|=> rvalid && rdata[2:0] == 3'h0)
		else $error("control 0 low bits not zero");
	AST_PAUSE: assert property ( // RULE22
		c0.counter_pause && !on_rise |=> count == $past(count))
		else $error("counter moved while paused");
	AST_INC: assert property ( // RULE24
		tick && running && !clear_now |=> count == $past(inc))
		else $error("counter did not step by one");
	AST_CLEAR_A: assert property ( // RULE17
		hit_a && c1.clear_source_select &&
		c1.mode_select == PTC_MODE_COMPARE |=> count == '0)
		else $error("compare A match did not clear counter");
	AST_PWM_CLR: assert property ( // RULE19
		hit_p && c1.mode_select == PTC_MODE_PWM |=> count == '0)
		else $error("pwm period not cleared by compare P");
	AST_HIGH_BYTE: assert property ( // RULE21
		arvalid && arready && araddr == `PTC_OFF_CNT_HI
		|=> rdata == {30'h0, $past(count[9:8])})
		else $error("high byte read wrong");
	AST_TOGGLE: assert property ( // RULE9
		hit_a && !on_rise && c1.mode_select == PTC_MODE_COMPARE &&
		c1.pin_function_select == 2'h3
		|=> out_level != $past(out_level) ##1
		timer_output_pin == ($past(out_level) ^ $past(c1.output_invert)))
		else $error("toggle on compare A failed");

endmodule : ptc_top

// File: core/ptc_params.svh
// constants of the periodic timer control block: offsets, fields, resets,
// clock dividers; included by the top module and the testbench.
// assumes byte addresses on a 32-bit AXI4-Lite bus, one register per word.
`ifndef PTC_PARAMS_SVH
`define PTC_PARAMS_SVH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define PTC_OFF_CTRL0   8'h00
`define PTC_OFF_CTRL1   8'h04
`define PTC_OFF_CNT_LO  8'h08
`define PTC_OFF_CNT_HI  8'h0C
`define PTC_OFF_CMP_A   8'h10
`define PTC_OFF_CMP_P   8'h14
`define PTC_OFF_STATUS  8'h18

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define PTC_C0_LSB      3
`define PTC_C0_MSB      7
`define PTC_CTRL0_RST   5'h00
`define PTC_CTRL1_RST   8'h00
`define PTC_STATUS_RST  3'h0

// ----------------------------------------------------------------------
// timing: system clock, fixed dividers, subclock rate
// ----------------------------------------------------------------------
`define PTC_CLK_HZ      100000000
`define PTC_SUB_HZ      32768
`define PTC_DIV_SYS4    6'h03
`define PTC_DIV_H16     6'h0F
`define PTC_DIV_H64     6'h3F

`endif

// File: core/ptc_pkg.sv
// types of the periodic timer control block.
// assumes ptc_params.svh is found on the include path.
package ptc_pkg;

	// ------------------------------------------------------------------
	// operating modes and clock sources
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {
		PTC_MODE_COMPARE = 2'h0,
		PTC_MODE_CAPTURE = 2'h1,
		PTC_MODE_PWM     = 2'h2,
		PTC_MODE_TIMER   = 2'h3
	} ptc_mode_t;

	typedef enum logic [2:0] {
		PTC_CK_SYS4  = 3'h0,
		PTC_CK_SYS   = 3'h1,
		PTC_CK_H16   = 3'h2,
		PTC_CK_H64   = 3'h3,
		PTC_CK_SUB0  = 3'h4,
		PTC_CK_SUB1  = 3'h5,
		PTC_CK_RISE  = 3'h6,
		PTC_CK_FALL  = 3'h7
	} ptc_clk_sel_t;

	// ------------------------------------------------------------------
	// control register layouts, msb first as in the byte
	// ------------------------------------------------------------------
	typedef struct packed {
		logic         counter_pause;
		ptc_clk_sel_t counter_clock_select;
		logic         counter_on;
	} ptc_ctrl0_t;

	typedef struct packed {
		ptc_mode_t  mode_select;
		logic [1:0] pin_function_select;
		logic       output_initial_level;
		logic       output_invert;
		logic       capture_source_select;
		logic       clear_source_select;
	} ptc_ctrl1_t;

endpackage : ptc_pkg

// File: dv/ptc_pin_model.sv
// pin-side partner of the timer: external clock pin and capture pin.
// assumes the bench calls its tasks just after a rising aclk edge.
`timescale 1ns/1ns

module ptc_pin_model (
	input  wire logic aclk,
	output logic      external_clock_pin,
	output logic      capture_input_pin
);
	// ------------------------------------------------------------------
	// idle levels: the clock pin stands low between bursts
	// ------------------------------------------------------------------
	initial begin
		external_clock_pin = 1'b0;
		capture_input_pin  = 1'b0;
	end

	// burst of n pulses, 4 cycles high and 4 low, well above the
	// 2-cycle minimum so the synchroniser never misses an edge
	task automatic burst(input int n);
		for (int i = 0; i < n; i++) begin
			repeat (4) @(posedge aclk);
			external_clock_pin <= 1'b1;
			repeat (4) @(posedge aclk);
			external_clock_pin <= 1'b0;
		end
		repeat (4) @(posedge aclk);
	endtask : burst

	// capture pin is a level; one change per call gives one edge
	task automatic set_cap(input logic v);
		@(posedge aclk);
		capture_input_pin <= v;
	endtask : set_cap
endmodule : ptc_pin_model

// File: dv/testbench.sv
// self-checking bench of the periodic timer control block.
// assumes the pin model drives the clock and capture pins.
`timescale 1ns/1ns
`include "ptc_params.svh"

module testbench;
	localparam int SUB = 8;
	logic        aclk;
	logic        aresetn;
	logic [7:0]  awaddr;
	logic        awvalid;
	logic        awready;
	logic [31:0] wdata;
	logic [3:0]  wstrb;
	logic        wvalid;
	logic        wready;
	logic [1:0]  bresp;
	logic        bvalid;
	logic        bready;
	logic [7:0]  araddr;
	logic        arvalid;
	logic        arready;
	logic [31:0] rdata;
	logic [1:0]  rresp;
	logic        rvalid;
	logic        rready;
	logic        ext_pin;
	logic        cap_pin;
	logic        tpin;
	logic        ten;
	int          num_errors;
	int          checks_done;
	int          cycles;
	logic [31:0] d;
	logic [1:0]  r;
	logic [9:0]  c;

	// ------------------------------------------------------------------
	// design, pin partner, clock, watchdog
	// ------------------------------------------------------------------
	ptc_top #(.SUB_DIV(SUB)) DUT (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.external_clock_pin(ext_pin), .capture_input_pin(cap_pin),
		.timer_output_pin(tpin), .timer_output_enable(ten));
	ptc_pin_model pins (.aclk(aclk), .external_clock_pin(ext_pin),
		.capture_input_pin(cap_pin));

	always #5 aclk = ~aclk;

	// a hang counts as a mismatch and ends the run
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cycles == 90000) begin
			num_errors++;
			end_of_test();
		end
	end

	// ------------------------------------------------------------------
	// bus tasks: hold each channel until its ready is sampled high
	// ------------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= v;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		fork
			begin
				do @(posedge aclk); while (awready !== 1'b1);
				awvalid <= 1'b0;
			end
			begin
				do @(posedge aclk); while (wready !== 1'b1);
				wvalid <= 1'b0;
			end
		join
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask : rd

	// ------------------------------------------------------------------
	// compare tasks, one per kind of result
	// ------------------------------------------------------------------
	// response code rides in the top two bits of both arguments
	task automatic chk_reg(input logic [33:0] g, input logic [33:0] e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t reg got %h exp %h", $time, g, e);
		end
	endtask : chk_reg

	task automatic chk_pin(input logic g, input logic e);
		checks_done++;
		if (g !== e) begin
			num_errors++;
			$display("BAD %0t pin got %b exp %b", $time, g, e);
		end
	endtask : chk_pin

	task automatic chk_rng(input logic [9:0] g, input int lo, input int hi);
		checks_done++;
		if ((^g === 1'bx) || g < lo || g > hi) begin
			num_errors++;
			$display("BAD %0t count %0d not in %0d..%0d", $time, g, lo, hi);
		end
	endtask : chk_rng

	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk_reg({r, d}, {2'h0, e});
	endtask : rchk

	task automatic rd_cnt();
		rd(`PTC_OFF_CNT_LO);
		c[7:0] = d[7:0];
		rd(`PTC_OFF_CNT_HI);
		c[9:8] = d[1:0];
	endtask : rd_cnt

	task automatic end_of_test();
		$display("errors %0d checks %0d", num_errors, checks_done);
		if (num_errors == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_of_test

	// ------------------------------------------------------------------
	// test tables: ctrl0 = {pause, select, on, 000}
	// ------------------------------------------------------------------
	logic [2:0] rs [6] = '{3'h1, 3'h0, 3'h2, 3'h3, 3'h4, 3'h5};
	int         rdv[6] = '{1, 4, 16, 64, SUB, SUB};
	int         rw [6] = '{300, 400, 800, 1600, 400, 400};
	logic [7:0] pc [10] = '{8'h00, 8'h18, 8'h10, 8'h20, 8'h3C, 8'h30,
		8'h88, 8'h94, 8'hA8, 8'hB8};
	logic       p0 [10] = '{0, 1, 0, 0, 0, 0, 0, 1, 1, 1};
	logic       p1 [10] = '{0, 0, 0, 1, 1, 1, 0, 1, 0, 0};
	logic [7:0] kc [8] = '{8'h40, 8'h40, 8'h50, 8'h50, 8'h60, 8'h70,
		8'h42, 8'h42};
	int         kl [8] = '{1, 0, 1, 0, 1, 0, 1, 2};
	logic       ke [8] = '{1, 0, 0, 1, 1, 0, 0, 1};
	logic [7:0] cc [3] = '{8'hC0, 8'h01, 8'h81};
	int         ca [3] = '{0, 3, 3};
	int         cn [3] = '{6, 4, 5};
	logic [9:0] ce [3] = '{10'h002, 10'h001, 10'h001};

	initial begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata} = '0;
		wstrb = 4'hF;
		{num_errors, checks_done, cycles} = '0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values, reserved bits, unmapped address
		rchk(`PTC_OFF_CTRL0, 32'h0);
		rchk(`PTC_OFF_CTRL1, 32'h0);
		rchk(`PTC_OFF_CNT_LO, 32'h0);
		rchk(`PTC_OFF_CNT_HI, 32'h0);
		wr(`PTC_OFF_CTRL0, 32'h07);
		rchk(`PTC_OFF_CTRL0, 32'h0);
		wr(`PTC_OFF_CTRL0, 32'hF7);
		rchk(`PTC_OFF_CTRL0, 32'hF0);
		// byte lanes: lane 1 alone must not touch control 0
		wr(`PTC_OFF_CMP_A, 32'h3FF);
		wstrb <= 4'h2;
		wr(`PTC_OFF_CTRL0, 32'h08);
		wr(`PTC_OFF_CMP_A, 32'h100);
		wstrb <= 4'hF;
		rchk(`PTC_OFF_CTRL0, 32'hF0);
		rchk(`PTC_OFF_CMP_A, 32'h1FF);
		rd(8'h1C);
		chk_reg({r, d}, {2'h2, 32'h0});
		$display("test registers done");
		// external edges, off keeps value, on zeroes, pause holds
		wr(`PTC_OFF_CTRL0, 32'h0);
		wr(`PTC_OFF_CTRL1, 32'hC0);
		wr(`PTC_OFF_CTRL0, 32'h68);
		pins.burst(5);
		rchk(`PTC_OFF_CNT_LO, 32'h5);
		wr(`PTC_OFF_CTRL0, 32'h00);
		pins.burst(2);
		rchk(`PTC_OFF_CNT_LO, 32'h5);
		wr(`PTC_OFF_CTRL0, 32'h78);
		rchk(`PTC_OFF_CNT_LO, 32'h0);
		pins.burst(3);
		rchk(`PTC_OFF_CNT_LO, 32'h3);
		wr(`PTC_OFF_CTRL0, 32'hE8);
		pins.burst(2);
		rchk(`PTC_OFF_CNT_LO, 32'h3);
		wr(`PTC_OFF_CTRL0, 32'h68);
		pins.burst(2);
		rchk(`PTC_OFF_CNT_LO, 32'h5);
		$display("test external count done");
		// internal sources: count over a timed run, high byte included
		for (int i = 0; i < 6; i++) begin
			wr(`PTC_OFF_CTRL0, {25'h0, rs[i], 4'h8});
			repeat (rw[i]) @(posedge aclk);
			wr(`PTC_OFF_CTRL0, {25'h0, rs[i], 4'h0});
			rd_cnt();
			chk_rng(c, rw[i] / rdv[i] - 1, rw[i] / rdv[i] + 12 / rdv[i] + 2);
		end
		// P zero: the counter wraps past 3FF back through zero
		wr(`PTC_OFF_CTRL0, 32'h18);
		repeat (1100) @(posedge aclk);
		wr(`PTC_OFF_CTRL0, 32'h10);
		rd_cnt();
		chk_rng(c, 75, 85);
		$display("test clock sources done");
		// clear source selection, ignored in pwm mode
		for (int i = 0; i < 3; i++) begin
			wr(`PTC_OFF_CTRL0, 32'h60);
			wr(`PTC_OFF_CTRL1, {24'h0, cc[i]});
			wr(`PTC_OFF_CMP_A, ca[i]);
			wr(`PTC_OFF_CMP_P, 32'h4);
			wr(`PTC_OFF_CTRL0, 32'h68);
			pins.burst(cn[i]);
			rd_cnt();
			chk_reg({22'h0, c}, {22'h0, ce[i]});
		end
		$display("test clear select done");
		// pin functions in compare and pwm modes, A=2 P=4
		wr(`PTC_OFF_CMP_A, 32'h2);
		for (int i = 0; i < 10; i++) begin
			wr(`PTC_OFF_CTRL0, 32'h60);
			wr(`PTC_OFF_CTRL1, {24'h0, pc[i]});
			wr(`PTC_OFF_CTRL0, 32'h68);
			repeat (4) @(posedge aclk);
			chk_pin(tpin, p0[i]);
			chk_pin(ten, 1'b1);
			pins.burst(2);
			chk_pin(tpin, p1[i]);
		end
		wr(`PTC_OFF_CTRL0, 32'h60);
		wr(`PTC_OFF_CTRL1, 32'hC0);
		repeat (3) @(posedge aclk);
		chk_pin(ten, 1'b0);
		$display("test output pin done");
		// capture edges and capture source
		for (int i = 0; i < 8; i++) begin
			wr(`PTC_OFF_CTRL0, 32'h10);
			wr(`PTC_OFF_CTRL1, {24'h0, kc[i]});
			wr(`PTC_OFF_STATUS, 32'h7);
			wr(`PTC_OFF_CTRL0, 32'h18);
			if (kl[i] == 2) begin
				pins.burst(1);
			end else begin
				pins.set_cap(kl[i][0]);
			end
			repeat (8) @(posedge aclk);
			rd(`PTC_OFF_STATUS);
			chk_pin(d[2], ke[i]);
		end
		$display("test capture done");
		// reset in mid-run: registers and counter return to zero
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rchk(`PTC_OFF_CTRL0, 32'h0);
		rchk(`PTC_OFF_STATUS, 32'h0);
		rchk(`PTC_OFF_CNT_LO, 32'h0);
		$display("test reset done");
		end_of_test();
	end
endmodule : testbench
